// ==== epf_flow_ctrl.sv ====
// Contract
// - priority pause frames handled only while their enable input is 1.
// - priority checks of addresses, ethertype, opcode each gated by qualifier.
// - valid pause frame sets its request bit, held until processed.
// - valid bit marks quanta usable; bit 8 for a global pause frame.
// - sixteen-bit quanta per priority; global quanta on the ninth output.
// - transmit request bit sends a pause frame; bit 8 global, others priority.
// - resend interval per slot comes from its sixteen-bit refresh input.
// - resend pulse resends frames of all active slots after current one, resets counters.
// - after a frame is sent the matching transmit valid bit is set.
// - receive user enable gates only the user-side request and valid outputs.
// - transmit enable gates sending of pause frames per slot.
// - global pause frames handled only while global enable is 1.
`default_nettype none
module epf_flow_ctrl
    import epf_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    // parsed pause frame from the receive decoder
    input wire logic rxFrameStrobe,
    input wire logic rxFrameIsGlobal,
    input wire logic [EPF_PRIOS-1:0] rxFrameClassEnable,
    input wire logic [EPF_QW-1:0] rxFrameQuanta [0:EPF_PRIOS-1],
    input wire logic rxFrameGroupDestMatch,
    input wire logic rxFrameSingleDestMatch,
    input wire logic rxFrameSourceAddrMatch,
    input wire logic rxFrameEthertypeMatch,
    input wire logic rxFrameOpcodeMatch,
    // receive controls
    input wire logic rxPriorityPauseFrameEnable,
    input wire logic rxPrioPauseCheckGroupDest,
    input wire logic rxPrioPauseCheckSingleDest,
    input wire logic rxPrioPauseCheckSourceAddr,
    input wire logic rxPrioPauseCheckEthertype,
    input wire logic rxPrioPauseCheckOpcode,
    input wire logic rxGlobalPauseFrameEnable,
    input wire logic rxGlobalPauseCheckGroupDest,
    input wire logic rxGlobalPauseCheckSingleDest,
    input wire logic rxGlobalPauseCheckSourceAddr,
    input wire logic rxGlobalPauseCheckEthertype,
    input wire logic rxGlobalPauseCheckOpcode,
    input wire logic [EPF_SLOTS-1:0] rxPauseUserEnable,
    input wire logic [EPF_SLOTS-1:0] rxPauseAcknowledge,
    output logic [EPF_SLOTS-1:0] rxPauseRequest,
    output logic [EPF_SLOTS-1:0] rxPauseValid,
    output logic [EPF_QW-1:0] rxPauseQuanta [0:EPF_SLOTS-1],
    // transmit controls
    input wire logic [EPF_SLOTS-1:0] txPauseSendRequest,
    input wire logic [EPF_SLOTS-1:0] txPauseSendEnable,
    input wire logic [EPF_QW-1:0] txPauseQuanta [0:EPF_SLOTS-1],
    input wire logic [EPF_QW-1:0] txPauseRefreshInterval [0:EPF_SLOTS-1],
    input wire logic txPauseResendPulse,
    output logic [EPF_SLOTS-1:0] txPauseValid,
    // pause frame hand-off to the transmit datapath
    output logic txFrameRequest,
    output logic txFrameIsGlobal,
    output logic [3:0] txFrameSlot,
    output logic [EPF_QW-1:0] txFrameQuanta,
    input wire logic txFrameDone
);
    logic prioOk;
    logic globalOk;
    logic [EPF_SLOTS-1:0] rxHit;
    logic [EPF_SLOTS-1:0] slotPending;
    logic [EPF_SLOTS-1:0] slotSent;
    logic [3:0] pickSlot;
    logic pickAny;
    logic [EPF_SLOTS-1:0] req_ff;
    logic [EPF_SLOTS-1:0] valid_ff;
    logic [EPF_SLOTS-1:0] txValid_ff;
    logic [EPF_QW-1:0] quanta_ff [0:EPF_SLOTS-1];
    logic frameReq_ff;
    logic frameGlobal_ff;
    logic [3:0] frameSlot_ff;
    logic [EPF_QW-1:0] frameQuanta_ff;
    epf_tx_state_e txState_ff;
    epf_tx_state_e nxt_txState;

    // frame qualification; an unchecked field always passes
    assign prioOk = rxFrameStrobe && !rxFrameIsGlobal
        && rxPriorityPauseFrameEnable
        && (!rxPrioPauseCheckGroupDest || rxFrameGroupDestMatch)
        && (!rxPrioPauseCheckSingleDest || rxFrameSingleDestMatch)
        && (!rxPrioPauseCheckSourceAddr || rxFrameSourceAddrMatch)
        && (!rxPrioPauseCheckEthertype || rxFrameEthertypeMatch)
        && (!rxPrioPauseCheckOpcode || rxFrameOpcodeMatch);
    assign globalOk = rxFrameStrobe && rxFrameIsGlobal
        && rxGlobalPauseFrameEnable
        && (!rxGlobalPauseCheckGroupDest || rxFrameGroupDestMatch)
        && (!rxGlobalPauseCheckSingleDest || rxFrameSingleDestMatch)
        && (!rxGlobalPauseCheckSourceAddr || rxFrameSourceAddrMatch)
        && (!rxGlobalPauseCheckEthertype || rxFrameEthertypeMatch)
        && (!rxGlobalPauseCheckOpcode || rxFrameOpcodeMatch);

    // global hit has no class bit; outputs come straight from registers
    assign rxHit[EPF_GLOBAL] = globalOk;
    assign rxPauseRequest = req_ff;
    assign rxPauseValid = valid_ff;
    assign txPauseValid = txValid_ff;
    assign txFrameRequest = frameReq_ff;
    assign txFrameIsGlobal = frameGlobal_ff;
    assign txFrameSlot = frameSlot_ff;
    assign txFrameQuanta = frameQuanta_ff;

    genvar gi;
    generate
        for (gi = 0; gi < EPF_SLOTS; gi++) begin : g_slot
            if (gi < EPF_PRIOS) begin : g_prio
                assign rxHit[gi] = prioOk && rxFrameClassEnable[gi];
            end
            assign rxPauseQuanta[gi] = quanta_ff[gi];

            // quanta capture is part of processing, not gated by user enable
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    quanta_ff[gi] <= EPF_QUANTA_RST;
                end else if (rxHit[gi]) begin
                    // a global frame carries its time in the first field
                    quanta_ff[gi] <= (gi == EPF_GLOBAL) ?
                        rxFrameQuanta[0] : rxFrameQuanta[gi % EPF_PRIOS];
                end
            end

            // request/valid handshake; a new frame beats a same-cycle ack
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    req_ff[gi] <= 1'b0;
                    valid_ff[gi] <= 1'b0;
                end else if (rxHit[gi]
                        && rxPauseUserEnable[gi]) begin
                    req_ff[gi] <= 1'b1;
                    valid_ff[gi] <= 1'b1;
                end else if (rxPauseAcknowledge[gi]) begin
                    req_ff[gi] <= 1'b0;
                    valid_ff[gi] <= 1'b0;
                end
            end

            epf_tx_slot u_slot (
                .clock(clock),
                .rst_b(rst_b),
                .sendRequest(txPauseSendRequest[gi]),
                .sendEnable(txPauseSendEnable[gi]),
                .refreshInterval(txPauseRefreshInterval[gi]),
                .resendPulse(txPauseResendPulse),
                .frameSent(slotSent[gi]),
                .pending(slotPending[gi])
            );

            assign slotSent[gi] = (txState_ff == EPF_TX_SEND) && txFrameDone
                && (frameSlot_ff == 4'(gi));
        end
    endgenerate

    // fixed priority: lowest slot first, global last
    always_comb begin
        pickAny = 1'b0;
        pickSlot = EPF_SLOT_RST;
        for (int i = EPF_SLOTS - 1; i >= 0; i--) begin
            if (slotPending[i]) begin
                pickAny = 1'b1;
                pickSlot = 4'(i);
            end
        end
    end

    // one pause frame in flight; new picks wait for its completion
    always_comb begin
        nxt_txState = txState_ff;
        unique case (txState_ff)
            EPF_TX_IDLE: begin
                if (pickAny) begin
                    nxt_txState = EPF_TX_SEND;
                end
            end
            EPF_TX_SEND: begin
                if (txFrameDone) begin
                    nxt_txState = EPF_TX_IDLE;
                end
            end
        endcase
    end

    // transmit state register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            txState_ff <= EPF_TX_IDLE;
        end else begin
            txState_ff <= nxt_txState;
        end
    end

    // frame descriptor latched at launch so quanta changes mid-frame are safe
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            frameReq_ff <= 1'b0;
            frameGlobal_ff <= 1'b0;
            frameSlot_ff <= EPF_SLOT_RST;
            frameQuanta_ff <= EPF_QUANTA_RST;
        end else if (txState_ff == EPF_TX_IDLE && pickAny) begin
            frameReq_ff <= 1'b1;
            frameGlobal_ff <= (pickSlot == 4'(EPF_GLOBAL));
            frameSlot_ff <= pickSlot;
            frameQuanta_ff <= txPauseQuanta[pickSlot];
        end else if (txState_ff == EPF_TX_SEND && txFrameDone) begin
            frameReq_ff <= 1'b0;
        end
    end

    // one-cycle report of each completed pause frame
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            txValid_ff <= EPF_MASK_RST;
        end else begin
            txValid_ff <= slotSent;
        end
    end
endmodule // epf_flow_ctrl
`default_nettype wire

// ==== epf_pkg.sv ====
`default_nettype none
package epf_pkg;
    localparam int EPF_SLOTS = 9;
    localparam int EPF_PRIOS = 8;
    localparam int EPF_GLOBAL = 8;
    localparam int EPF_QW = 16;
    localparam logic [EPF_QW-1:0] EPF_QUANTA_RST = 16'h0000;
    localparam logic [EPF_QW-1:0] EPF_TIMER_ZERO = 16'h0000;
    localparam logic [EPF_QW-1:0] EPF_TIMER_STEP = 16'h0001;
    localparam logic [3:0] EPF_SLOT_RST = 4'h0;
    localparam logic [EPF_SLOTS-1:0] EPF_MASK_RST = 9'h000;

    typedef enum logic [0:0] {
        EPF_TX_IDLE = 1'b0,
        EPF_TX_SEND = 1'b1
    } epf_tx_state_e;
endpackage
`default_nettype wire

// ==== epf_tx_slot.sv ====
`default_nettype none
module epf_tx_slot
    import epf_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic sendRequest,
    input wire logic sendEnable,
    input wire logic [EPF_QW-1:0] refreshInterval,
    input wire logic resendPulse,
    input wire logic frameSent,
    output logic pending
);
    logic reqPrev_ff;
    logic armed_ff;
    logic pending_ff;
    logic [EPF_QW-1:0] timer_ff;
    logic active;
    logic expire;

    // a slot only acts while asked for and allowed to send
    assign active = sendRequest && sendEnable;
    assign expire = armed_ff && (timer_ff == EPF_TIMER_ZERO);
    assign pending = pending_ff;

    // remember the request for edge detection
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reqPrev_ff <= 1'b0;
        end else begin
            reqPrev_ff <= active;
        end
    end

    // pending set wins over the clear from a sent frame
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pending_ff <= 1'b0;
        end else if (active && !reqPrev_ff) begin
            pending_ff <= 1'b1;
        end else if (active && resendPulse) begin
            pending_ff <= 1'b1;
        end else if (active && expire) begin
            pending_ff <= 1'b1;
        end else if (frameSent || !active) begin
            pending_ff <= 1'b0;
        end
    end

    // refresh countdown, one count per clock, restarted by each send
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            armed_ff <= 1'b0;
            timer_ff <= EPF_TIMER_ZERO;
        end else if (!active || resendPulse) begin
            armed_ff <= 1'b0;
            timer_ff <= EPF_TIMER_ZERO;
        end else if (frameSent) begin
            armed_ff <= 1'b1;
            timer_ff <= refreshInterval;
        end else if (expire) begin
            armed_ff <= 1'b0;
        end else if (armed_ff) begin
            timer_ff <= timer_ff - EPF_TIMER_STEP;
        end
    end
endmodule // epf_tx_slot
`default_nettype wire

// ==== epf_user_model.sv ====
`default_nettype none
// stands for the user logic and the transmit datapath around the block
module epf_user_model
    import epf_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] ackDelay,
    input wire logic [7:0] doneDelay,
    input wire logic [EPF_SLOTS-1:0] rxPauseRequest,
    input wire logic txFrameRequest,
    output logic [EPF_SLOTS-1:0] rxPauseAcknowledge,
    output logic txFrameDone
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ackCnt_ff;
    logic [7:0] doneCnt_ff;
    // acknowledge what is raised after a chosen delay, long or short
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ackCnt_ff <= 8'h00;
            rxPauseAcknowledge <= 9'h000;
        end else if (|rxPauseRequest && !(|rxPauseAcknowledge)) begin
            ackCnt_ff <= ackCnt_ff + 8'h01;
            if (ackCnt_ff == ackDelay) begin
                rxPauseAcknowledge <= rxPauseRequest;
            end
        end else begin
            ackCnt_ff <= 8'h00;
            rxPauseAcknowledge <= 9'h000;
        end
    end
    // datapath finishes a frame after a chosen delay; one-cycle pulse
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            doneCnt_ff <= 8'h00;
            txFrameDone <= 1'b0;
        end else if (txFrameRequest && !txFrameDone) begin
            doneCnt_ff <= doneCnt_ff + 8'h01;
            txFrameDone <= (doneCnt_ff == doneDelay);
        end else begin
            doneCnt_ff <= 8'h00;
            txFrameDone <= 1'b0;
        end
    end
endmodule // epf_user_model
`default_nettype wire

// ==== epf_flow_ctrl_chk_assertions.sv ====
`default_nettype none
module epf_flow_ctrl_chk
    import epf_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic rxFrameStrobe,
    input wire logic [EPF_QW-1:0] rxFrameQuanta [0:EPF_PRIOS-1],
    input wire logic rxGlobalPauseFrameEnable,
    input wire logic [EPF_SLOTS-1:0] rxPauseAcknowledge,
    input wire logic [EPF_SLOTS-1:0] rxPauseRequest,
    input wire logic [EPF_SLOTS-1:0] rxPauseValid,
    input wire logic [EPF_QW-1:0] rxPauseQuanta [0:EPF_SLOTS-1],
    input wire logic [EPF_SLOTS-1:0] txPauseValid,
    input wire logic txFrameRequest,
    input wire logic txFrameIsGlobal,
    input wire logic [3:0] txFrameSlot,
    input wire logic [EPF_QW-1:0] txFrameQuanta,
    input wire logic txFrameDone
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // frame in flight keeps its descriptor until done is seen
    sequence s_held;
        ##1 txFrameRequest && $stable(txFrameSlot) && $stable(txFrameQuanta);
    endsequence
    // one-cycle report of the slot that just finished
    sequence s_report;
        ##1 txPauseValid == (9'h001 << $past(txFrameSlot))
        ##1 txPauseValid == 9'h000;
    endsequence
    property p_reqValid; rxPauseRequest == rxPauseValid; endproperty
    a_reqValid: assert property (p_reqValid)
        else $error("request and valid differ");
    property p_reqHold;
        ($past(rxPauseRequest) & ~$past(rxPauseAcknowledge)
            & ~rxPauseRequest) == 9'h000;
    endproperty
    a_reqHold: assert property (p_reqHold)
        else $error("request dropped without acknowledge");
    property p_ackClear;
        |rxPauseAcknowledge && !rxFrameStrobe |=>
            (rxPauseRequest & $past(rxPauseAcknowledge)) == 9'h000;
    endproperty
    a_ackClear: assert property (p_ackClear)
        else $error("request kept after acknowledge");
    property p_globalCause;
        $rose(rxPauseRequest[8]) |->
            $past(rxFrameStrobe && rxGlobalPauseFrameEnable);
    endproperty
    a_globalCause: assert property (p_globalCause)
        else $error("global request without enabled frame");
    property p_globalQuanta;
        $rose(rxPauseRequest[8]) |->
            rxPauseQuanta[8] == $past(rxFrameQuanta[0]);
    endproperty
    a_globalQuanta: assert property (p_globalQuanta)
        else $error("global quanta not in ninth slot");
    property p_txHold; txFrameRequest && !txFrameDone |-> s_held; endproperty
    a_txHold: assert property (p_txHold)
        else $error("frame descriptor changed in flight");
    property p_txReport;
        txFrameRequest && txFrameDone |-> s_report;
    endproperty
    a_txReport: assert property (p_txReport)
        else $error("sent frame not reported");
    property p_txFlag;
        txFrameRequest |-> txFrameIsGlobal == (txFrameSlot == 4'h8);
    endproperty
    a_txFlag: assert property (p_txFlag)
        else $error("global flag disagrees with slot");
endmodule // epf_flow_ctrl_chk
bind epf_flow_ctrl epf_flow_ctrl_chk epf_flow_ctrl_chk_i (.*);
`default_nettype wire

// ==== testbench.sv ====
`default_nettype none
module testbench
    import epf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst_b = 1'b0, rxFrameStrobe = 1'b0;
    logic rxFrameIsGlobal = 1'b0, txPauseResendPulse = 1'b0;
    logic rxPriorityPauseFrameEnable = 1'b1, rxGlobalPauseFrameEnable = 1'b1;
    logic txFrameRequest, txFrameIsGlobal, txFrameDone;
    logic [3:0] txFrameSlot;
    logic [4:0] mat = 5'h1F, pChk = 5'h1F, gChk = 5'h1F;
    logic [7:0] rxFrameClassEnable = 8'h00;
    logic [7:0] ackDelay = 8'h28, doneDelay = 8'h02;
    logic [8:0] rxPauseUserEnable = 9'h1FF, txPauseSendRequest = 9'h000;
    logic [8:0] txPauseSendEnable = 9'h1FF, rxPauseRequest, rxPauseValid;
    logic [8:0] rxPauseAcknowledge, txPauseValid;
    logic [15:0] txFrameQuanta, rxFrameQuanta [0:7], rxPauseQuanta [0:8];
    logic [15:0] txPauseQuanta [0:8], txPauseRefreshInterval [0:8];
    int fail_count = 0, check_count = 0, n = 0;
    // 40 MHz
    always #12.5 clock = ~clock;
    // checks and match results are vectors so one loop walks them all
    epf_flow_ctrl epf_flow_ctrl_i (.*,
        .rxFrameGroupDestMatch(mat[0]), .rxFrameSingleDestMatch(mat[1]),
        .rxFrameSourceAddrMatch(mat[2]), .rxFrameEthertypeMatch(mat[3]),
        .rxFrameOpcodeMatch(mat[4]), .rxPrioPauseCheckGroupDest(pChk[0]),
        .rxPrioPauseCheckSingleDest(pChk[1]),
        .rxPrioPauseCheckSourceAddr(pChk[2]),
        .rxPrioPauseCheckEthertype(pChk[3]), .rxPrioPauseCheckOpcode(pChk[4]),
        .rxGlobalPauseCheckGroupDest(gChk[0]),
        .rxGlobalPauseCheckSingleDest(gChk[1]),
        .rxGlobalPauseCheckSourceAddr(gChk[2]),
        .rxGlobalPauseCheckEthertype(gChk[3]),
        .rxGlobalPauseCheckOpcode(gChk[4]));
    epf_user_model epf_user_model_i (.*);
    // one compare; case inequality so an unknown never passes
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one cycle of a bounded wait; running out counts as a mismatch
    task automatic tick;
        @(negedge clock);
        n++;
        if (n > 600) begin
            chk(16'h0000, 16'h0001);
            results();
        end
    endtask
    // one parsed frame from the decoder, outputs sampled once settled
    task automatic rxFrame(input logic glb, input logic [7:0] cls);
        @(posedge clock);
        rxFrameStrobe <= 1'b1;
        rxFrameIsGlobal <= glb;
        rxFrameClassEnable <= cls;
        @(posedge clock);
        rxFrameStrobe <= 1'b0;
        @(negedge clock);
    endtask
    task automatic waitClr;
        n = 0;
        while (rxPauseRequest !== 9'h000) tick();
    endtask
    task automatic txFrame(input int s);
        n = 0;
        while (txFrameRequest !== 1'b1) tick();
        chk({12'h000, txFrameSlot}, 16'(s));
        chk({15'h0000, txFrameIsGlobal}, 16'(s == EPF_GLOBAL));
        chk(txFrameQuanta, txPauseQuanta[s]);
        while (txPauseValid === 9'h000) tick();
        chk({7'h00, txPauseValid}, 16'h0001 << s);
        @(negedge clock);
    endtask
    initial begin
        for (int i = 0; i < 9; i++) begin
            txPauseQuanta[i] = 16'h1100 + 16'(i);
            txPauseRefreshInterval[i] = 16'h00C8;
            if (i < 8) rxFrameQuanta[i] = 16'hA000 + 16'(i);
        end
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        // two classes at once; slow user side, so requests must stand
        rxFrame(1'b0, 8'h09);
        chk({7'h00, rxPauseValid}, 16'h0009);
        chk(rxPauseQuanta[3], 16'hA003);
        repeat (20) @(negedge clock);
        chk({7'h00, rxPauseRequest}, 16'h0009);
        waitClr();
        ackDelay <= 8'h02;
        rxFrame(1'b1, 8'h00);
        chk({7'h00, rxPauseRequest}, 16'h0100);
        chk(rxPauseQuanta[8], 16'hA000);
        waitClr();
        @(posedge clock);
        rxPriorityPauseFrameEnable <= 1'b0;
        rxGlobalPauseFrameEnable <= 1'b0;
        rxFrame(1'b0, 8'hFF);
        rxFrame(1'b1, 8'h00);
        chk({7'h00, rxPauseRequest}, 16'h0000);
        @(posedge clock);
        rxPriorityPauseFrameEnable <= 1'b1;
        rxGlobalPauseFrameEnable <= 1'b1;
        rxPauseUserEnable <= 9'h1F7;
        rxFrameQuanta[3] <= 16'h5A5A;
        rxFrame(1'b0, 8'h08);
        chk({7'h00, rxPauseRequest}, 16'h0000);
        chk(rxPauseQuanta[3], 16'h5A5A);
        // each field in turn: a failing field drops the frame until unchecked
        for (int g = 0; g < 2; g++)
            for (int k = 0; k < 5; k++) begin
                @(posedge clock);
                rxPauseUserEnable <= 9'h1FF;
                mat <= ~(5'h01 << k);
                pChk <= 5'h1F;
                gChk <= 5'h1F;
                rxFrame(1'(g), 8'h10);
                chk({7'h00, rxPauseRequest}, 16'h0000);
                @(posedge clock);
                if (g == 0) pChk <= ~(5'h01 << k);
                else gChk <= ~(5'h01 << k);
                rxFrame(1'(g), 8'h10);
                chk({7'h00, rxPauseRequest}, g ? 16'h0100 : 16'h0010);
                waitClr();
            end
        // all nine slots at once: lowest first, global last
        @(posedge clock);
        txPauseSendRequest <= 9'h1FF;
        for (int s = 0; s < 9; s++) txFrame(s);
        @(posedge clock);
        txPauseSendRequest <= 9'h000;
        repeat (16) @(posedge clock);
        txPauseSendEnable <= 9'h1DF;
        txPauseSendRequest <= 9'h020;
        repeat (30) @(negedge clock)
            chk({15'h0000, txFrameRequest}, 16'h0000);
        @(posedge clock);
        txPauseSendEnable <= 9'h1FF;
        txFrame(5);
        @(posedge clock);
        txPauseRefreshInterval[2] <= 16'h0014;
        txPauseSendRequest <= 9'h004;
        txFrame(2);
        txFrame(2);
        chk(16'(n >= 20 && n <= 40), 16'h0001);
        @(posedge clock);
        txPauseRefreshInterval[2] <= 16'h00C8;
        txPauseResendPulse <= 1'b1;
        @(posedge clock);
        txPauseResendPulse <= 1'b0;
        txFrame(2);
        chk(16'(n <= 10), 16'h0001);
        @(posedge clock);
        txPauseSendRequest <= 9'h000;
        repeat (16) @(posedge clock);
        results();
    end
endmodule // testbench
`default_nettype wire
